//--- logic/hth_pkg.sv
// Shared constants for the humidity and temperature readout block
`default_nettype none
package hth_pkg;
    // Register offsets on the two-wire register port
    localparam logic [7:0] HTH_OFS_RUN_MODE_SELECT = 8'h21;
    localparam logic [7:0] HTH_OFS_MEAS_TRIGGER    = 8'h22;
    localparam logic [7:0] HTH_OFS_MEAS_HALT       = 8'h23;
    localparam logic [7:0] HTH_OFS_MEAS_ACTIVITY   = 8'h24;
    localparam logic [7:0] HTH_OFS_TEMP_RESULT     = 8'h30;
    localparam logic [7:0] HTH_OFS_HUM_RESULT      = 8'h33;
    localparam logic [7:0] HTH_RESULT_BYTES        = 8'h03;

    // Per-sensor bit positions in run, trigger, halt and activity
    localparam int HTH_BIT_TEMP = 0;
    localparam int HTH_BIT_HUM  = 1;

    // Result word layout
    localparam int HTH_RES_CRC_MSB = 23;
    localparam int HTH_RES_CRC_LSB = 17;
    localparam int HTH_RES_VALID   = 16;
    localparam int HTH_RES_DATA_MSB = 15;

    // Reset values
    localparam logic [1:0]  HTH_RST_RUN      = 2'h0;
    localparam logic [1:0]  HTH_RST_ACTIVITY = 2'h0;
    localparam logic [23:0] HTH_RST_RESULT   = 24'h000000;

    // Bus slave address and checksum settings (arbitrary defaults)
    localparam logic [6:0] HTH_SLAVE_ADDR = 7'h43;
    localparam logic [6:0] HTH_CRC_POLY   = 7'h09;
    localparam logic [6:0] HTH_CRC_INIT   = 7'h7f;

    // Two-wire slave states, one-hot
    typedef enum logic [6:0] {
        HTH_ST_IDLE    = 7'h01,
        HTH_ST_ADDR    = 7'h02,
        HTH_ST_ADDR_AK = 7'h04,
        HTH_ST_WR_BYTE = 7'h08,
        HTH_ST_WR_AK   = 7'h10,
        HTH_ST_RD_BYTE = 7'h20,
        HTH_ST_RD_AK   = 7'h40
    } hth_i2c_state_e;
endpackage
`default_nettype wire

//--- logic/hth_crc7.sv
// Seven-bit checksum over a sample value and its valid flag
`timescale 1ns/100ps
`default_nettype none
module hth_crc7
    import hth_pkg::*;
(
    input  wire logic [16:0] i_msg,
    output logic      [6:0]  o_crc
);
    // Bitwise shift register, message taken MSB first
    always_comb
    begin
        logic [6:0] crc;
        logic       fb;
        crc = HTH_CRC_INIT;
        fb  = 1'b0;
        for (int i = 16; i >= 0; i--)
        begin
            fb  = crc[6] ^ i_msg[i];
            crc = {crc[5:0], 1'b0};
            if (fb)
            begin
                crc = crc ^ HTH_CRC_POLY;
            end
        end
        o_crc = crc;
    end
endmodule
`default_nettype wire

//--- logic/hth_meas_ctrl.sv
// One sensor's measurement sequencer and result register
`timescale 1ns/100ps
`default_nettype none
module hth_meas_ctrl
    import hth_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic        i_halt,
    input  wire logic        i_cont,
    input  wire logic        i_done,
    input  wire logic [15:0] i_data,
    input  wire logic        i_valid,
    input  wire logic [6:0]  i_crc,
    output logic             o_busy,
    output logic             o_conv_req,
    output logic      [23:0] o_result
);
    logic cont_r;
    logic busy_r;
    logic req_r;
    logic [23:0] result_r;

    // Activity flag and conversion requests; halt only ends a
    // continuous run, a single shot always completes
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_r <= 1'b0;
            cont_r <= 1'b0;
            req_r  <= 1'b0;
        end
        else if (i_halt && cont_r)
        begin
            busy_r <= 1'b0;
            cont_r <= 1'b0;
            req_r  <= 1'b0;
        end
        else if (i_start && !busy_r)
        begin
            busy_r <= 1'b1;
            cont_r <= i_cont;
            req_r  <= 1'b1;
        end
        else if (i_done && busy_r)
        begin
            busy_r <= cont_r;
            req_r  <= cont_r;
        end
        else
        begin
            req_r <= 1'b0;
        end
    end

    // Latest sample with its flag and checksum
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            result_r <= HTH_RST_RESULT;
        end
        else if (i_done && busy_r)
        begin
            result_r <= {i_crc, i_valid, i_data};
        end
    end

    assign o_busy     = busy_r;
    assign o_conv_req = req_r;
    assign o_result   = result_r;
endmodule
`default_nettype wire

//--- logic/hth_readout.sv
// Two-wire register slave with measurement control and readout
`timescale 1ns/100ps
`default_nettype none
module hth_readout
    import hth_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe,
    output logic             o_t_conv_req,
    input  wire logic        i_t_done,
    input  wire logic [15:0] i_t_data,
    input  wire logic        i_t_valid,
    output logic             o_h_conv_req,
    input  wire logic        i_h_done,
    input  wire logic [15:0] i_h_data,
    input  wire logic        i_h_valid
);
    hth_i2c_state_e state_r;
    logic        scl_q_r;
    logic        sda_q_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  tx_r;
    logic [7:0]  ptr_r;
    logic        first_wr_r;
    logic        rd_nack_r;
    logic        sda_oe_r;
    logic [1:0]  run_r;
    logic [1:0]  start_r;
    logic [1:0]  halt_r;
    logic [23:0] hold_t_r;
    logic [23:0] hold_h_r;

    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic        byte_end;
    logic        wr_stb;
    logic        rd_load;
    logic [7:0]  rd_byte;
    logic [1:0]  busy;
    logic [23:0] result [2];

    // Per-sensor input lanes, index 0 temperature, 1 humidity
    logic [1:0]  conv_req;
    logic [1:0]  done_in;
    logic [1:0]  valid_in;
    logic [15:0] data_in [2];

    assign done_in  = {i_h_done, i_t_done};
    assign valid_in = {i_h_valid, i_t_valid};
    assign data_in[0] = i_t_data;
    assign data_in[1] = i_h_data;

    // One sequencer and checksum per sensor
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_sens
            logic [6:0] crc;
            hth_crc7 u_crc (
                .i_msg (({valid_in[g], data_in[g]})),
                .o_crc (crc)
            );
            hth_meas_ctrl u_ctrl (
                .i_clk_sys  (i_clk_sys),
                .i_rst      (i_rst),
                .i_start    (start_r[g]),
                .i_halt     (halt_r[g]),
                .i_cont     (run_r[g]),
                .i_done     (done_in[g]),
                .i_data     (data_in[g]),
                .i_valid    (valid_in[g]),
                .i_crc      (crc),
                .o_busy     (busy[g]),
                .o_conv_req (conv_req[g]),
                .o_result   (result[g])
            );
        end
    endgenerate

    assign o_t_conv_req = conv_req[HTH_BIT_TEMP];
    assign o_h_conv_req = conv_req[HTH_BIT_HUM];

    // Pins are sampled once for edge and condition detection
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= i_scl;
            sda_q_r <= i_sda;
        end
    end

    assign scl_rise  = i_scl & ~scl_q_r;
    assign scl_fall  = ~i_scl & scl_q_r;
    assign bus_start = i_scl & scl_q_r & sda_q_r & ~i_sda;
    assign bus_stop  = i_scl & scl_q_r & ~sda_q_r & i_sda;
    assign byte_end  = scl_fall && (bit_cnt_r == 4'h8);
    assign wr_stb    = (state_r == HTH_ST_WR_BYTE) && byte_end && !first_wr_r;
    assign rd_load   = scl_fall && !rd_nack_r &&
                       (((state_r == HTH_ST_ADDR_AK) && shift_r[0]) ||
                        (state_r == HTH_ST_RD_AK));

    // Read mux; result bytes after the first come from the holding copy
    always_comb
    begin
        rd_byte = 8'h00;
        if (ptr_r == HTH_OFS_RUN_MODE_SELECT)
        begin
            rd_byte = {6'h00, run_r};
        end
        else if (ptr_r == HTH_OFS_MEAS_ACTIVITY)
        begin
            rd_byte = {6'h00, busy};
        end
        else if (ptr_r == HTH_OFS_TEMP_RESULT)
        begin
            rd_byte = result[HTH_BIT_TEMP][7:0];
        end
        else if (ptr_r == HTH_OFS_TEMP_RESULT + 8'h01)
        begin
            rd_byte = hold_t_r[15:8];
        end
        else if (ptr_r == HTH_OFS_TEMP_RESULT + 8'h02)
        begin
            rd_byte = hold_t_r[23:16];
        end
        else if (ptr_r == HTH_OFS_HUM_RESULT)
        begin
            rd_byte = result[HTH_BIT_HUM][7:0];
        end
        else if (ptr_r == HTH_OFS_HUM_RESULT + 8'h01)
        begin
            rd_byte = hold_h_r[15:8];
        end
        else if (ptr_r == HTH_OFS_HUM_RESULT + 8'h02)
        begin
            rd_byte = hold_h_r[23:16];
        end
    end

    // Bus protocol sequencer; a start or stop aborts any transfer
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r    <= HTH_ST_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            sda_oe_r   <= 1'b0;
            first_wr_r <= 1'b1;
            rd_nack_r  <= 1'b0;
        end
        else if (bus_start)
        begin
            state_r    <= HTH_ST_ADDR;
            bit_cnt_r  <= 4'h0;
            sda_oe_r   <= 1'b0;
            first_wr_r <= 1'b1;
            rd_nack_r  <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_r  <= HTH_ST_IDLE;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                HTH_ST_ADDR, HTH_ST_WR_BYTE:
                begin
                    if (scl_rise)
                    begin
                        shift_r   <= {shift_r[6:0], i_sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (byte_end && state_r == HTH_ST_ADDR)
                    begin
                        // Only acknowledge our own address
                        if (shift_r[7:1] == HTH_SLAVE_ADDR)
                        begin
                            sda_oe_r <= 1'b1;
                            state_r  <= HTH_ST_ADDR_AK;
                        end
                        else
                        begin
                            state_r <= HTH_ST_IDLE;
                        end
                    end
                    else if (byte_end)
                    begin
                        first_wr_r <= 1'b0;
                        sda_oe_r   <= 1'b1;
                        state_r    <= HTH_ST_WR_AK;
                    end
                end
                HTH_ST_ADDR_AK, HTH_ST_WR_AK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == HTH_ST_ADDR_AK && shift_r[0])
                        begin
                            tx_r     <= rd_byte;
                            sda_oe_r <= ~rd_byte[7];
                            state_r  <= HTH_ST_RD_BYTE;
                        end
                        else
                        begin
                            sda_oe_r <= 1'b0;
                            state_r  <= HTH_ST_WR_BYTE;
                        end
                    end
                end
                HTH_ST_RD_BYTE:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        sda_oe_r <= 1'b0;
                        state_r  <= HTH_ST_RD_AK;
                    end
                    else if (scl_fall)
                    begin
                        sda_oe_r <= ~tx_r[3'h7 - bit_cnt_r[2:0]];
                    end
                end
                HTH_ST_RD_AK:
                begin
                    if (scl_rise)
                    begin
                        rd_nack_r <= i_sda;
                    end
                    else if (scl_fall && rd_nack_r)
                    begin
                        // Master declined more data; wait for stop
                        state_r <= HTH_ST_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        tx_r      <= rd_byte;
                        sda_oe_r  <= ~rd_byte[7];
                        state_r   <= HTH_ST_RD_BYTE;
                    end
                end
                default:
                begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // Register pointer: set by first written byte, steps per data byte
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            ptr_r <= 8'h00;
        end
        else if (state_r == HTH_ST_WR_BYTE && byte_end && first_wr_r
                 && !bus_start && !bus_stop)
        begin
            ptr_r <= shift_r;
        end
        else if ((wr_stb || rd_load) && !bus_start && !bus_stop)
        begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // Holding copies, frozen when the first result byte is fetched
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            hold_t_r <= HTH_RST_RESULT;
            hold_h_r <= HTH_RST_RESULT;
        end
        else if (rd_load && !bus_start && !bus_stop)
        begin
            if (ptr_r == HTH_OFS_TEMP_RESULT)
            begin
                hold_t_r <= result[HTH_BIT_TEMP];
            end
            if (ptr_r == HTH_OFS_HUM_RESULT)
            begin
                hold_h_r <= result[HTH_BIT_HUM];
            end
        end
    end

    // Run mode register, read/write
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            run_r <= HTH_RST_RUN;
        end
        else if (wr_stb && !bus_start && !bus_stop
                 && ptr_r == HTH_OFS_RUN_MODE_SELECT)
        begin
            run_r <= shift_r[1:0];
        end
    end

    // Trigger and halt are one-cycle strobes; a zero bit gives no strobe
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            start_r <= 2'h0;
            halt_r  <= 2'h0;
        end
        else
        begin
            start_r <= (wr_stb && !bus_start && !bus_stop &&
                        ptr_r == HTH_OFS_MEAS_TRIGGER) ?
                       shift_r[1:0] : 2'h0;
            halt_r  <= (wr_stb && !bus_start && !bus_stop &&
                        ptr_r == HTH_OFS_MEAS_HALT) ?
                       shift_r[1:0] : 2'h0;
        end
    end

    // Open-drain pin: only ever pulls low
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_sda_out <= 1'b0;
        end
        else
        begin
            o_sda_out <= 1'b0;
        end
    end

    assign o_sda_oe = sda_oe_r;
endmodule
`default_nettype wire

//--- verif/hth_readout_sva.sv
// Bus pin and conversion request timing checker for the readout block
`timescale 1ns/100ps
`default_nettype none
module hth_readout_sva
    import hth_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_scl,
    input wire logic        i_sda,
    input wire logic        o_sda_out,
    input wire logic        o_sda_oe,
    input wire logic        o_t_conv_req,
    input wire logic        i_t_done,
    input wire logic [15:0] i_t_data,
    input wire logic        i_t_valid,
    input wire logic        o_h_conv_req,
    input wire logic        i_h_done,
    input wire logic [15:0] i_h_data,
    input wire logic        i_h_valid
);
    logic       scl_q;
    logic [3:0] fall_age;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    // Cycles since the bus clock fell, saturating so it never wraps
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_q    <= 1'b1;
            fall_age <= 4'hf;
        end
        else
        begin
            scl_q <= i_scl;
            if (scl_q && !i_scl)
                fall_age <= 4'h0;
            else if (fall_age != 4'hf)
                fall_age <= fall_age + 4'h1;
        end
    end

    // Requests are single-cycle pulses
    sequence s_t_pulse;
        o_t_conv_req ##1 !o_t_conv_req;
    endsequence
    sequence s_h_pulse;
        o_h_conv_req ##1 !o_h_conv_req;
    endsequence
    property p_t_pulse;
        o_t_conv_req |-> s_t_pulse;
    endproperty
    property p_h_pulse;
        o_h_conv_req |-> s_h_pulse;
    endproperty
    // A request follows a bus write or a finished conversion
    property p_t_cause;
        o_t_conv_req |-> fall_age <= 4'h6 || $past(i_t_done)
            || $past(i_t_done, 2) || $past(i_t_done, 3);
    endproperty
    property p_h_cause;
        o_h_conv_req |-> fall_age <= 4'h6 || $past(i_h_done)
            || $past(i_h_done, 2) || $past(i_h_done, 3);
    endproperty
    // Data pin only changes shortly after a bus clock fall
    property p_oe_rise;
        $rose(o_sda_oe) |-> !i_scl && fall_age <= 4'h3;
    endproperty
    property p_oe_fall;
        $fell(o_sda_oe) |-> !i_scl && fall_age <= 4'h3;
    endproperty
    property p_oe_hold;
        i_scl && $past(i_scl) && $past(i_scl, 2) |-> $stable(o_sda_oe);
    endproperty
    property p_sda_low;
        o_sda_oe |-> o_sda_out == 1'b0;
    endproperty

    a_t_pulse: assert property (p_t_pulse)
        else $error("temperature request too long");
    a_h_pulse: assert property (p_h_pulse)
        else $error("humidity request too long");
    a_t_cause: assert property (p_t_cause)
        else $error("temperature request without cause");
    a_h_cause: assert property (p_h_cause)
        else $error("humidity request without cause");
    a_oe_rise: assert property (p_oe_rise)
        else $error("data pin driven at wrong time");
    a_oe_fall: assert property (p_oe_fall)
        else $error("data pin released at wrong time");
    a_oe_hold: assert property (p_oe_hold)
        else $error("data pin moved while bus clock high");
    a_sda_low: assert property (p_sda_low)
        else $error("data pin driven high");
endmodule

bind hth_readout hth_readout_sva chk_u (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .o_t_conv_req(o_t_conv_req), .i_t_done(i_t_done),
    .i_t_data(i_t_data), .i_t_valid(i_t_valid),
    .o_h_conv_req(o_h_conv_req), .i_h_done(i_h_done),
    .i_h_data(i_h_data), .i_h_valid(i_h_valid)
);
`default_nettype wire

//--- verif/hth_host_model.sv
// Two-wire bus master standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module hth_host_model
    import hth_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_drv
);
    localparam int HALF = 4; // Clocks per phase, above the 2 the slave needs
    logic ack_ok;

    initial
    begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
        ack_ok = 1'b1;
    end
    // Pins move only just after a falling clock edge
    task automatic tick();
        repeat (HALF) @(negedge i_clk_sys);
    endtask
    // Start or repeated start: data falls while bus clock is high
    task automatic start_cond();
        tick();
        o_sda_drv = 1'b1;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda_drv = 1'b0;
        tick();
        o_scl = 1'b0;
    endtask
    task automatic stop_cond();
        tick();
        o_sda_drv = 1'b0;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda_drv = 1'b1;
        tick();
    endtask
    // Data set while clock low, line sampled late in the high phase
    task automatic bit_xfer(input logic b, output logic r);
        tick();
        o_sda_drv = b;
        tick();
        o_scl = 1'b1;
        tick();
        r = i_sda_line;
        o_scl = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        if (r !== 1'b0)
            ack_ok = 1'b0;
    endtask
    // Last byte is refused so the slave lets go of the line
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, d[i]);
        bit_xfer(last, r);
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
        start_cond();
        put_byte({HTH_SLAVE_ADDR, 1'b0});
        put_byte(ofs);
        put_byte(d);
        stop_cond();
    endtask
    // Reads from the lowest byte up, assembled little endian
    task automatic read_reg(input logic [7:0] ofs, input int n,
                            output logic [23:0] v);
        logic [7:0] b;
        v = 24'h000000;
        start_cond();
        put_byte({HTH_SLAVE_ADDR, 1'b0});
        put_byte(ofs);
        start_cond();
        put_byte({HTH_SLAVE_ADDR, 1'b1});
        for (int i = 0; i < n; i++)
        begin
            get_byte(i == n - 1, b);
            v[8 * i +: 8] = b;
        end
        stop_cond();
    endtask
endmodule
`default_nettype wire

//--- verif/hth_readout_tb.sv
// Self-checking bench for the humidity and temperature readout block
`timescale 1ns/100ps
`default_nettype none
module hth_readout_tb
    import hth_pkg::*;
();
    localparam int LAT = 1500; // Conversion time, longer than a status read
    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    logic        scl;
    logic        sda_drv;
    logic        sda_out;
    logic        sda_oe;
    logic        sda_line;
    logic        t_req;
    logic        h_req;
    logic [1:0]  done_q = 2'b00;
    logic [16:0] smp [2] = '{17'h15a3c, 17'h0c1d7};
    logic [16:0] fe [2] = '{17'h00000, 17'h00000};
    int          cnt [2] = '{-1, -1};
    int          bad_count = 0;
    int          comparisons = 0;
    logic [23:0] rd;
    logic [23:0] old;

    always #10 i_clk_sys = ~i_clk_sys;
    // Open-drain line with pull-up
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

    hth_readout dut_u (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_rst),
        .i_scl        (scl),
        .i_sda        (sda_line),
        .o_sda_out    (sda_out),
        .o_sda_oe     (sda_oe),
        .o_t_conv_req (t_req),
        .i_t_done     (done_q[0]),
        .i_t_data     (fe[0][15:0]),
        .i_t_valid    (fe[0][16]),
        .o_h_conv_req (h_req),
        .i_h_done     (done_q[1]),
        .i_h_data     (fe[1][15:0]),
        .i_h_valid    (fe[1][16])
    );
    hth_host_model host_u (
        .i_clk_sys  (i_clk_sys),
        .i_sda_line (sda_line),
        .o_scl      (scl),
        .o_sda_drv  (sda_drv)
    );

    // Front ends answer after LAT; data shows garbage outside done
    always @(negedge i_clk_sys)
    begin
        for (int s = 0; s < 2; s++)
        begin
            done_q[s] = 1'b0;
            if (s == 0 ? t_req : h_req)
                cnt[s] = LAT;
            else if (cnt[s] == 0)
                done_q[s] = 1'b1;
            if (cnt[s] >= 0)
                cnt[s]--;
            fe[s] = done_q[s] ? smp[s] : ~smp[s];
        end
    end

    function automatic logic [23:0] word(input logic [16:0] m);
        logic [6:0] c;
        c = HTH_CRC_INIT;
        for (int i = 16; i >= 0; i--)
            c = {c[5:0], 1'b0} ^ ((c[6] ^ m[i]) ? HTH_CRC_POLY : 7'h00);
        return {c, m};
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] ofs, input int n,
                          input logic [23:0] exp);
        host_u.read_reg(ofs, n, rd);
        check(rd, exp);
    endtask
    // Sampled on the rising edge, where the front end output is settled
    task automatic wait_done(input int s);
        int n;
        n = 0;
        while (done_q[s] !== 1'b1 && n < 4000)
        begin
            @(posedge i_clk_sys);
            n++;
        end
        check(24'(n >= 4000), 24'h000000);
        repeat (3) @(negedge i_clk_sys);
    endtask
    task automatic conclude();
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #(20 * 60000);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        conclude();
    end

    initial
    begin
        repeat (3) @(negedge i_clk_sys);
        i_rst = 1'b0;
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000000);
        rd_chk(HTH_OFS_TEMP_RESULT, 3, HTH_RST_RESULT);
        rd_chk(HTH_OFS_HUM_RESULT, 3, HTH_RST_RESULT);
        // Single shot temperature, a halt it ignores, then a zero trigger
        host_u.write_reg(HTH_OFS_RUN_MODE_SELECT, 8'h00);
        host_u.write_reg(HTH_OFS_MEAS_TRIGGER, 8'h01);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000001);
        host_u.write_reg(HTH_OFS_MEAS_HALT, 8'h01);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000001);
        wait_done(0);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000000);
        rd_chk(HTH_OFS_TEMP_RESULT, 3, word(smp[0]));
        host_u.write_reg(HTH_OFS_MEAS_TRIGGER, 8'h00);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000000);
        // Both continuous; humidity sample is flagged invalid
        host_u.write_reg(HTH_OFS_RUN_MODE_SELECT, 8'h03);
        rd_chk(HTH_OFS_RUN_MODE_SELECT, 1, 24'h000003);
        host_u.write_reg(HTH_OFS_MEAS_TRIGGER, 8'h03);
        wait_done(1);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000003);
        rd_chk(HTH_OFS_HUM_RESULT, 3, word(smp[1]));
        // First byte freezes the others while a new sample lands
        old = word(smp[0]);
        rd_chk(HTH_OFS_TEMP_RESULT, 1, {16'h0000, old[7:0]});
        smp[0] = 17'h10e81;
        wait_done(0);
        rd_chk(HTH_OFS_TEMP_RESULT + 8'h01, 2, {8'h00, old[23:8]});
        rd_chk(HTH_OFS_TEMP_RESULT, 3, word(smp[0]));
        // Halt one sensor at a time
        host_u.write_reg(HTH_OFS_MEAS_HALT, 8'h00);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000003);
        host_u.write_reg(HTH_OFS_MEAS_HALT, 8'h01);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000002);
        host_u.write_reg(HTH_OFS_MEAS_HALT, 8'h02);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000000);
        // Write-only and unmapped places read zero
        host_u.write_reg(8'h25, 8'hff);
        rd_chk(8'h25, 1, 24'h000000);
        rd_chk(HTH_OFS_MEAS_ACTIVITY, 1, 24'h000000);
        rd_chk(HTH_OFS_MEAS_HALT, 1, 24'h000000);
        check({23'h000000, host_u.ack_ok}, 24'h000001);
        // A foreign slave address gets no acknowledge
        host_u.start_cond();
        host_u.put_byte({HTH_SLAVE_ADDR ^ 7'h01, 1'b0});
        host_u.stop_cond();
        check({23'h000000, host_u.ack_ok}, 24'h000000);
        conclude();
    end
endmodule
`default_nettype wire
